// File: lcfs_pkg.sv
/*
  Shared constants and types of the LED channel fault supervisor.
  Assumes a single 40 MHz core clock feeding every module that imports it.
*/
package lcfs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Channel count and clock
  localparam int LCFS_NUM_CH = 3;
  localparam int LCFS_CLK_HZ = 40_000_000;

  ////////////////////////////////////////////////////////////////////////////
  // Deglitch timing
  localparam int LCFS_DEGLITCH_MS   = 2;
  localparam int LCFS_DEGLITCH_CLKS = LCFS_DEGLITCH_MS * (LCFS_CLK_HZ / 1000);
  localparam int LCFS_OPEN_CYCLES   = 7;
  localparam int LCFS_SHORT_CYCLES  = 7;
  localparam int LCFS_SINGLE_CYCLES = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm line read-back settle time before an external override is judged
  localparam int             LCFS_SETTLE_W    = 3;
  localparam logic [2:0]     LCFS_SETTLE_CLKS = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // General alarm driver states
  typedef enum logic [2:0] {
    LCFS_ALM_IDLE = 3'h1,
    LCFS_ALM_PULL = 3'h2,
    LCFS_ALM_FREE = 3'h4
  } lcfs_alm_e;

endpackage : lcfs_pkg

// File: lcfs_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; output moves only when stages two and three agree.
*/
`timescale 1ns/1ps
module lcfs_sync
  import lcfs_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lcfs_sync_s;

  lcfs_sync_s st_r;
  lcfs_sync_s st_nxt;

  if (W < 1) begin : g_chk
    $error("lcfs_sync width must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds stage two only
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q  = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3)); // RULE20
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule : lcfs_sync

// File: lcfs_deglitch.sv
/*
  Fault deglitch qualifier for one comparator of one channel.
  Assumes cond and active are synchronous; active is the channel's own on state.
  Qualifies after LIMIT clocks of continuous on-time or CYCLES whole on-times.
*/
`timescale 1ns/1ps
module lcfs_deglitch
  import lcfs_pkg::*;
#(
  parameter int LIMIT  = LCFS_DEGLITCH_CLKS,
  parameter int CYCLES = LCFS_OPEN_CYCLES
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic clear,
  input  wire logic active,
  input  wire logic cond,
  output logic      qualified
);

  localparam int TW = $clog2(LIMIT + 1);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [TW-1:0] T_LAST = TW'(LIMIT - 1);
  localparam logic [CW-1:0] C_LAST = CW'(CYCLES - 1);

  if (LIMIT < 2 || CYCLES < 1) begin : g_chk
    $error("lcfs_deglitch needs LIMIT of two or more and CYCLES of one or more");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [TW-1:0] timer;
    logic [CW-1:0] cycles;
    logic          held;
    logic          prev_on;
    logic          qual;
  } lcfs_dgl_s;

  lcfs_dgl_s st_r;
  lcfs_dgl_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Qualification; comparator is only trusted while the channel conducts
  always_comb begin
    st_nxt         = st_r;
    st_nxt.prev_on = active;
    if (clear) begin
      st_nxt = '0;
    end else if (active) begin
      if (!st_r.prev_on) begin
        st_nxt.held  = 1'h1;
        st_nxt.timer = '0;
      end
      if (cond) begin
        if (st_nxt.timer >= T_LAST) begin
          st_nxt.qual = 1'h1; // RULE13
        end else begin
          st_nxt.timer = st_nxt.timer + 1'h1;
        end
      end else begin
        st_nxt.held   = 1'h0; // RULE13
        st_nxt.timer  = '0;
        st_nxt.cycles = '0;
        st_nxt.qual   = 1'h0;
      end
    end else if (st_r.prev_on && st_r.held) begin
      if (st_r.cycles >= C_LAST) begin
        st_nxt.qual = 1'h1; // RULE18
      end else begin
        st_nxt.cycles = st_r.cycles + 1'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign qualified = st_r.qual;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_qual_needs_cond: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(qualified) |-> $past(cond) || $past(st_r.held)) // RULE13
    else $error("qualified rose without a standing condition");

endmodule : lcfs_deglitch

// File: lcfs_supervisor.sv
/*
  LED channel fault supervisor: channel gating, fault latches, alarm drivers.
  Assumes comparator outputs and pins are asynchronous, and that the alarm
  wires carry a weak pull-up resolved outside this module.
*/
//
// Behaviour
// (RULE1) Each dimming input gates its own channel; held low keeps that channel off.
// (RULE2) Both alarm pins only pull low; a weak pull-up sits outside the logic.
// (RULE3) General alarm line low, from any of up to 15 drivers, turns all off.
// (RULE4) Release the general pull-down on external override, enable toggle or power-up.
// (RULE5) Thermal and open-load alarms release by themselves once the cause is gone.
// (RULE6) Output short, single short and reference faults latch their alarms.
// (RULE7) General alarm for thermal, open, short, reference; single alarm for single short.
// (RULE8) Single short reported only while supply is qualified above 9V.
// (RULE9) Single short only reports; channel keeps sourcing until host turns it off.
// (RULE10) Single alarm tied to general line shuts all channels via the bus.
// (RULE11) Whole-string short pulls the general line low, turning all channels off.
// (RULE12) With the line held high, a string short turns off only its channel.
// (RULE13) Open load deglitched by 2ms of on-time or seven whole dimming cycles.
// (RULE14) Open load with free line: pull low, open channel on, others off.
// (RULE15) Open load with the line held high keeps all channels on.
// (RULE16) Without a host only power cycling clears latched faults.
// (RULE17) Three string sense comparators feed per-channel single short detection.
// (RULE18) Short and single-short conditions deglitched over seven dimming cycles.
// (RULE19) Reference resistor fault turns all strings off and latches until cleared.
// (RULE20) Inputs synchronised; deglitch timing from the clock and dimming edges.
// (RULE21) Latches, counters and channel-off states cleared by enable toggle and reset.
//
`timescale 1ns/1ps
module lcfs_supervisor
  import lcfs_pkg::*;
#(
  parameter int NUM_CH        = LCFS_NUM_CH,
  parameter int DEGLITCH_CLKS = LCFS_DEGLITCH_CLKS
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              chip_enable,
  input  wire logic [NUM_CH-1:0] channel_dim_input,
  input  wire logic [NUM_CH-1:0] output_short_cmp,
  input  wire logic [NUM_CH-1:0] open_load_cmp,
  input  wire logic [NUM_CH-1:0] string_sense_input,
  input  wire logic              thermal_cmp,
  input  wire logic              ref_fault_cmp,
  input  wire logic              supply_ok_cmp,
  input  wire logic              gen_alarm_i,
  output logic                   gen_alarm_o,
  output logic                   gen_alarm_oe,
  input  wire logic              single_alarm_i,
  output logic                   single_alarm_o,
  output logic                   single_alarm_oe,
  output logic      [NUM_CH-1:0] channel_current_output
);

  localparam int SW = 4 * NUM_CH + 6;

  if (NUM_CH < 1 || DEGLITCH_CLKS < 2) begin : g_chk
    $error("lcfs_supervisor needs one channel or more and a deglitch of two clocks or more");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [SW-1:0]     sync_q;
  logic              en_s;
  logic [NUM_CH-1:0] dim_s;
  logic [NUM_CH-1:0] short_s;
  logic [NUM_CH-1:0] open_s;
  logic [NUM_CH-1:0] sense_s;
  logic              thermal_s;
  logic              ref_s;
  logic              supply_ok_s;
  logic              gen_in_s;
  logic              single_in_s;

  lcfs_sync #(
    .W (SW)
  ) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({chip_enable, channel_dim_input, output_short_cmp, open_load_cmp,
              string_sense_input, thermal_cmp, ref_fault_cmp, supply_ok_cmp,
              gen_alarm_i, single_alarm_i}),
    .q      (sync_q)
  );

  assign {en_s, dim_s, short_s, open_s, sense_s, thermal_s, ref_s, supply_ok_s,
          gen_in_s, single_in_s} = sync_q; // RULE20

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [NUM_CH-1:0]        short_lat;
    logic [NUM_CH-1:0]        single_lat;
    logic                     ref_lat;
    lcfs_alm_e                alm;
    logic [LCFS_SETTLE_W-1:0] settle;
    logic [NUM_CH-1:0]        chan_on;
    logic                     single_oe;
  } lcfs_sup_s;

  lcfs_sup_s st_r;
  lcfs_sup_s st_nxt;

  logic              clr;
  logic [NUM_CH-1:0] short_q;
  logic [NUM_CH-1:0] open_q;
  logic [NUM_CH-1:0] single_q;
  logic              gen_req;
  logic              bus_low;

  // Enable low holds everything cleared, so a low-high toggle is a full clear
  assign clr     = !en_s; // RULE21
  assign bus_low = !gen_in_s; // RULE3

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel deglitch, timed on the channel's own conduction
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    lcfs_deglitch #(
      .LIMIT  (DEGLITCH_CLKS),
      .CYCLES (LCFS_SHORT_CYCLES)
    ) u_short (
      .clock     (clock),
      .arst_n    (arst_n),
      .clear     (clr),
      .active    (st_r.chan_on[i]),
      .cond      (short_s[i]), // RULE18
      .qualified (short_q[i])
    );

    lcfs_deglitch #(
      .LIMIT  (DEGLITCH_CLKS),
      .CYCLES (LCFS_OPEN_CYCLES)
    ) u_open (
      .clock     (clock),
      .arst_n    (arst_n),
      .clear     (clr),
      .active    (st_r.chan_on[i]),
      .cond      (open_s[i]), // RULE13
      .qualified (open_q[i])
    );

    lcfs_deglitch #(
      .LIMIT  (DEGLITCH_CLKS),
      .CYCLES (LCFS_SINGLE_CYCLES)
    ) u_single (
      .clock     (clock),
      .arst_n    (arst_n),
      .clear     (clr),
      .active    (st_r.chan_on[i]),
      .cond      (sense_s[i] && supply_ok_s), // RULE17 RULE8
      .qualified (single_q[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latches, alarm driver and channel gating
  always_comb begin
    st_nxt = st_r;

    // Set wins over clear for short and single latches; deglitchers are cleared too, so clear still lands
    st_nxt.short_lat  = (clr ? '0 : st_r.short_lat) | short_q; // RULE6 RULE16
    st_nxt.single_lat = (clr ? '0 : st_r.single_lat)
                      | (single_q & {NUM_CH{supply_ok_s}}); // RULE6 RULE8
    st_nxt.ref_lat    = (clr ? 1'h0 : st_r.ref_lat) | (ref_s && en_s); // RULE19

    // Live causes need no latch, so their alarm drops with the cause
    gen_req = (|st_nxt.short_lat) || (|open_q) || thermal_s || st_nxt.ref_lat; // RULE7 RULE5

    if (clr) begin
      st_nxt.alm    = LCFS_ALM_IDLE; // RULE4
      st_nxt.settle = '0;
    end else begin
      case (st_r.alm)
        LCFS_ALM_IDLE: begin
          if (gen_req) begin
            st_nxt.alm    = LCFS_ALM_PULL; // RULE11 RULE14
            st_nxt.settle = '0;
          end
        end
        // Settle spans the read-back lag, else our own pull would look overridden
        LCFS_ALM_PULL: begin
          if (!gen_req) begin
            st_nxt.alm = LCFS_ALM_IDLE; // RULE5
          end else if (st_r.settle < LCFS_SETTLE_CLKS) begin
            st_nxt.settle = st_r.settle + 1'h1;
          end else if (gen_in_s) begin
            // Line high while pulling means a stronger source overrides us
            st_nxt.alm = LCFS_ALM_FREE; // RULE4
          end
        end
        LCFS_ALM_FREE: begin
          st_nxt.alm = LCFS_ALM_FREE;
        end
        default: begin
          st_nxt.alm = LCFS_ALM_IDLE;
        end
      endcase
    end

    // Single short never gates a channel by itself; only via a tied bus
    for (int i = 0; i < NUM_CH; i++) begin
      st_nxt.chan_on[i] = en_s && dim_s[i] // RULE1 RULE9
                        && !thermal_s && !st_nxt.ref_lat // RULE19
                        && !st_nxt.short_lat[i] // RULE12
                        && !(bus_low && !open_q[i]); // RULE3 RULE10 RULE14 RULE15
    end

    st_nxt.single_oe = |st_nxt.single_lat; // RULE7
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{short_lat: '0, single_lat: '0, ref_lat: 1'h0, alm: LCFS_ALM_IDLE,
                settle: '0, chan_on: '0, single_oe: 1'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins; drivers only sink, the level comes from the wire's pull-up
  assign gen_alarm_o            = 1'h0; // RULE2
  assign single_alarm_o         = 1'h0; // RULE2
  assign gen_alarm_oe           = (st_r.alm == LCFS_ALM_PULL);
  assign single_alarm_oe        = st_r.single_oe;
  assign channel_current_output = st_r.chan_on;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Antecedents use synced inputs, which trail the pins by four clocks

  for (genvar i = 0; i < NUM_CH; i++) begin : g_chk_ch
    a_dim_gates_chan: assert property ( // RULE1
      !dim_s[i] |=> !channel_current_output[i])
      else $error("channel on with its dimming input low");

    a_short_chan_off: assert property ( // RULE12
      short_q[i] && en_s |=> !channel_current_output[i] ##1 !channel_current_output[i])
      else $error("shorted channel still on");

    a_open_keeps_on: assert property ( // RULE14
      open_q[i] && dim_s[i] && en_s && !thermal_s && !st_nxt.ref_lat
      && !st_nxt.short_lat[i] |=> channel_current_output[i])
      else $error("open-load channel turned off");

    a_short_latched: assert property ( // RULE6
      st_r.short_lat[i] && en_s |=> st_r.short_lat[i])
      else $error("short latch lost while enabled");

    a_single_keeps_on: assert property ( // RULE9
      st_r.single_lat[i] && gen_in_s && dim_s[i] && en_s && !thermal_s && !st_nxt.ref_lat
      && !st_nxt.short_lat[i] |=> channel_current_output[i])
      else $error("single short turned its channel off");
  end

  a_bus_low_off: assert property ( // RULE3
    bus_low && (open_q == '0) |=> (channel_current_output == '0))
    else $error("channel on while general alarm line low");

  a_thermal_off: assert property ( // RULE5
    thermal_s |=> (channel_current_output == '0))
    else $error("channel on during thermal shutdown");

  a_thermal_pull: assert property ( // RULE7
    thermal_s && en_s && (st_r.alm == LCFS_ALM_IDLE) |=> gen_alarm_oe)
    else $error("thermal shutdown did not pull the general alarm");

  a_open_pull: assert property ( // RULE14
    (|open_q) && en_s && (st_r.alm == LCFS_ALM_IDLE) |=> gen_alarm_oe)
    else $error("qualified open load did not pull the general alarm");

  a_alarm_release: assert property ( // RULE5
    gen_alarm_oe && !thermal_s && (open_q == '0) && (st_nxt.short_lat == '0)
    && !st_nxt.ref_lat |=> !gen_alarm_oe)
    else $error("general alarm held after its causes cleared");

  a_override_rel: assert property ( // RULE4
    (gen_alarm_oe && gen_in_s) [*5] |=> !gen_alarm_oe)
    else $error("general alarm still pulled under external override");

  a_ref_latched: assert property ( // RULE19
    st_r.ref_lat && en_s |=> st_r.ref_lat && (channel_current_output == '0))
    else $error("reference fault latch lost or strings on");

  a_single_supply: assert property ( // RULE8
    $rose(single_alarm_oe) |-> $past(supply_ok_s))
    else $error("single short reported without qualified supply");

  a_en_clears: assert property ( // RULE21
    (!en_s) [*3] |=> (st_r.short_lat == '0) && (st_r.single_lat == '0)
    && !st_r.ref_lat && !gen_alarm_oe && !single_alarm_oe)
    else $error("enable low did not clear the fault state");

  c_open_pull: cover property (|open_q && gen_alarm_oe);
  c_override:  cover property (st_r.alm == LCFS_ALM_FREE && |st_r.short_lat);
  c_single:    cover property (single_alarm_oe && !single_in_s);
  c_thermal:   cover property (thermal_s && gen_alarm_oe);
  c_ref:       cover property (st_r.ref_lat && gen_alarm_oe);

endmodule : lcfs_supervisor

// File: lcfs_alarm_partner.sv
/*
  Far side of the alarm wires: weak pull-ups, a host able to hold the general
  line high, another driver on the bus and an optional tie of the two wires.
  Assumes oe high means the supervisor pulls the pin low.
*/
`timescale 1ns/1ps
module lcfs_alarm_partner (
  input  wire logic gen_alarm_oe,
  input  wire logic single_alarm_oe,
  input  wire logic hold_high,
  input  wire logic other_pull,
  input  wire logic tie_single,
  output wire logic gen_alarm_i,
  output wire logic single_alarm_i
);
  ////////////////////////////////////////////////////////////////////////////
  logic gen_pulled;
  logic tied_level;

  // Any device on the bus may pull the shared line
  assign gen_pulled = gen_alarm_oe | other_pull;
  // Strong host pull-up beats every pull-down; else weak pull-up
  assign tied_level = hold_high | ~(gen_pulled | single_alarm_oe);
  assign gen_alarm_i = tie_single ? tied_level : (hold_high | ~gen_pulled);
  assign single_alarm_i = tie_single ? tied_level : ~single_alarm_oe;
endmodule : lcfs_alarm_partner

// File: led_channel_fault_supervisor_bench.sv
/*
  Self-checking bench of the supervisor with a short deglitch time.
  Assumes the partner model resolves both alarm wires.
*/
`timescale 1ns/1ps
module led_channel_fault_supervisor_bench;
  import lcfs_pkg::*;
  localparam int DG = 20;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        chip_enable = 1'b1;
  logic [2:0]  dim = 3'h7;
  logic [2:0]  short_c = 3'h0;
  logic [2:0]  open_c = 3'h0;
  logic [2:0]  sense = 3'h0;
  logic        thermal = 1'b0;
  logic        ref_f = 1'b0;
  logic        supply_ok = 1'b0;
  logic        hold_high = 1'b0;
  logic        other_pull = 1'b0;
  logic        tie_single = 1'b0;
  wire logic   gen_i;
  wire logic   single_i;
  logic        gen_o;
  logic        gen_oe;
  logic        single_o;
  logic        single_oe;
  logic [2:0]  ch_out;
  logic [31:0] seed = 32'h000034E1;
  logic [4:0]  exp_q[$];
  int          mismatches = 0;
  int          comparisons = 0;
  event        probe;

  ////////////////////////////////////////////////////////////////////////////
  lcfs_supervisor #(.NUM_CH(3), .DEGLITCH_CLKS(DG)) u_lcfs_supervisor (
    .clock(clock), .arst_n(arst_n), .chip_enable(chip_enable),
    .channel_dim_input(dim), .output_short_cmp(short_c), .open_load_cmp(open_c),
    .string_sense_input(sense), .thermal_cmp(thermal), .ref_fault_cmp(ref_f),
    .supply_ok_cmp(supply_ok), .gen_alarm_i(gen_i), .gen_alarm_o(gen_o),
    .gen_alarm_oe(gen_oe), .single_alarm_i(single_i), .single_alarm_o(single_o),
    .single_alarm_oe(single_oe), .channel_current_output(ch_out));

  lcfs_alarm_partner u_lcfs_alarm_partner (
    .gen_alarm_oe(gen_oe), .single_alarm_oe(single_oe), .hold_high(hold_high),
    .other_pull(other_pull), .tie_single(tie_single), .gen_alarm_i(gen_i),
    .single_alarm_i(single_i));

  always #12.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs_next(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs_next

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle

  // Toggle channel zero through n on-times of five clocks each
  task automatic pulse_ch0(input int n);
    for (int p = 1; p <= n; p++) begin
      dim[0] = 1'b1;
      settle(5);
      dim[0] = 1'b0;
      settle(5);
    end
  endtask : pulse_ch0

  // Note expected {channels, general oe, single oe}; watcher compares
  task automatic chk(input logic [4:0] e);
    exp_q.push_back(e);
    ->probe;
  endtask : chk

  // Enable low then high clears latches and counters
  task automatic clear_all;
    chip_enable = 1'b0;
    settle(8);
    chip_enable = 1'b1;
    settle(8);
  endtask : clear_all

  task automatic summarize;
    // One clock lets the watcher take the last note
    settle(1);
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(probe) begin
    logic [4:0] e;
    logic [4:0] got;
    e = exp_q.pop_front();
    got = {ch_out, gen_oe, single_oe};
    comparisons++;
    if (got !== e || gen_o !== 1'b0 || single_o !== 1'b0) begin
      mismatches++;
      $display("[ERR] ch_gen_single exp %b got %b", e, got);
    end
  end

  // Hang guard; settles are the only waits and all are fixed
  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(2);
    arst_n = 1'b1;
    settle(8);
    for (int i = 0; i < 8; i++) begin
      seed = xs_next(seed);
      dim = seed[2:0];
      settle(8);
      chk({seed[2:0], 2'b00});
    end
    dim = 3'h7;
    settle(8);
    // Open load, continuous on, line free
    open_c = 3'h1;
    settle(40);
    chk(5'b00110);
    open_c = 3'h0;
    settle(12);
    chk(5'b11100);
    // Open load in dimming mode: first on-time is partial, eighth pulse qualifies
    open_c = 3'h1;
    pulse_ch0(7);
    chk(5'b11000);
    pulse_ch0(1);
    settle(12);
    chk(5'b00010);
    open_c = 3'h0;
    dim = 3'h7;
    settle(12);
    chk(5'b11100);
    // Open load with line held high keeps all on
    hold_high = 1'b1;
    open_c = 3'h2;
    settle(40);
    chk(5'b11100);
    open_c = 3'h0;
    clear_all();
    // String short with line held high: only that channel off
    short_c = 3'h1;
    settle(40);
    chk(5'b11000);
    short_c = 3'h0;
    settle(12);
    chk(5'b11000);
    clear_all();
    hold_high = 1'b0;
    settle(8);
    // String short with line free: all off, latched
    short_c = 3'h4;
    settle(40);
    chk(5'b00010);
    short_c = 3'h0;
    settle(12);
    chk(5'b00010);
    clear_all();
    chk(5'b11100);
    // Single short needs qualified supply; channels keep sourcing
    sense = 3'h2;
    settle(40);
    chk(5'b11100);
    supply_ok = 1'b1;
    settle(40);
    chk(5'b11101);
    sense = 3'h0;
    settle(12);
    chk(5'b11101);
    tie_single = 1'b1;
    settle(12);
    chk(5'b00001);
    clear_all();
    tie_single = 1'b0;
    settle(8);
    // Another driver pulls the shared line
    other_pull = 1'b1;
    settle(12);
    chk(5'b00000);
    other_pull = 1'b0;
    settle(12);
    chk(5'b11100);
    // Thermal releases by itself
    thermal = 1'b1;
    settle(12);
    chk(5'b00010);
    thermal = 1'b0;
    settle(12);
    chk(5'b11100);
    // Reference fault latches until enable toggle
    ref_f = 1'b1;
    settle(12);
    chk(5'b00010);
    ref_f = 1'b0;
    settle(12);
    chk(5'b00010);
    clear_all();
    chk(5'b11100);
    // Output short in dimming mode, line free: seven whole on-times qualify
    short_c = 3'h1;
    pulse_ch0(7);
    chk(5'b11000);
    pulse_ch0(1);
    settle(12);
    chk(5'b00010);
    short_c = 3'h0;
    dim = 3'h7;
    clear_all();
    chk(5'b11100);
    summarize();
  end
endmodule : led_channel_fault_supervisor_bench
